// ==== modbus_master_model.sv ====
// Link master model: decodes response bytes sent on the line.
// Assumes the line idles high and bits last BIT_LEN clock cycles.
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model #(
  parameter int BIT_LEN = 4
) (
  // Clock
  input wire logic sys_clk,
  // Line and decoded bytes
  input wire logic txd,
  output logic [7:0] rx_data,
  output logic rx_done,
  output logic frame_err
);
  logic [7:0] b;
  initial begin
    rx_data = 8'h00;
    rx_done = 1'b0;
    frame_err = 1'b0;
  end
  always begin
    @(negedge txd);
    repeat (BIT_LEN / 2) @(posedge sys_clk);
    if (txd !== 1'b0) frame_err = 1'b1;
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_LEN) @(posedge sys_clk);
      b[i] = txd;
    end
    repeat (BIT_LEN) @(posedge sys_clk);
    // Sticky, so a bad stop bit anywhere is still seen at the end
    if (txd !== 1'b1) frame_err = 1'b1;
    rx_data = b;
    rx_done = 1'b1;
    @(posedge sys_clk);
    rx_done = 1'b0;
  end
endmodule
`default_nettype wire

// ==== readout_pkg.sv ====
// Constants shared by the holding-register readout and its serial sender.
// Assumes a 25 MHz system clock and a 19200 baud 8/N/1 link.
package readout_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_RATE = 19200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int MAX_QTY = 125;
  localparam logic [15:0] STATUS_ADDR = 16'h08fc;
  localparam logic [15:0] CH0_ADDR = 16'h08fd;
  localparam logic [15:0] CH1_ADDR = 16'h08ff;
  localparam logic [15:0] CH2_ADDR = 16'h0901;
  localparam logic [15:0] CH3_ADDR = 16'h0903;
  localparam logic [15:0] LAST_ADDR = 16'h0904;
  localparam int CHANGED_BIT = 15;
  localparam int FAULT_LO = 0;
  localparam int FAULT_HI = 3;
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam int HDR_BYTES = 3;
  localparam int CRC_BYTES = 2;
endpackage

// ==== serial_byte_tx.sv ====
// Byte sender for the half-duplex link: start, eight data bits, stop.
// Assumes the driver holds data steady while valid is high.
`timescale 1ns/1ps
`default_nettype none
module serial_byte_tx
  import readout_pkg::*;
#(
  parameter int BIT_LEN = BIT_CYCLES
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Byte in
  input wire logic [7:0] data,
  input wire logic valid,
  output logic ready,
  // Line
  output logic txd
);
  if (BIT_LEN < 2 || BIT_LEN > 65535) begin : g_bit_len_check
    $error("BIT_LEN out of range");
  end

  localparam logic [15:0] BIT_LAST = 16'(BIT_LEN - 1);
  logic [8:0] shreg;
  logic [3:0] bits_left;
  logic [15:0] cnt;
  wire take = ready && valid;
  wire cnt_done = cnt == 16'h0000;

  // RQ8: one bit per baud period
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ready <= 1'b1;
      txd <= 1'b1;
      shreg <= 9'h000;
      bits_left <= 4'h0;
      cnt <= 16'h0000;
    end else if (clk_en) begin
      if (take) begin
        txd <= 1'b0;
        shreg <= {1'b1, data};
        bits_left <= 4'h9;
        cnt <= BIT_LAST;
        ready <= 1'b0;
      end else if (!ready) begin
        if (!cnt_done) begin
          cnt <= cnt - 16'h0001;
        end else if (bits_left != 4'h0) begin
          txd <= shreg[0];
          shreg <= {1'b1, shreg[8:1]};
          bits_left <= bits_left - 4'h1;
          cnt <= BIT_LAST;
        end else begin
          ready <= 1'b1;
        end
      end
    end
  end

  a_start_bit_len: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && take |=> !txd && cnt == BIT_LAST) // RQ8
    else $error("start bit not one baud period");
  a_stop_level: assert property (@(posedge sys_clk) disable iff (srst)
    ready |-> txd) // RQ8
    else $error("line not idle high between bytes");
endmodule
`default_nettype wire

// ==== status_readout.sv ====
// Holding-register readout: status word, channel values, read responses.
// Assumes a frame decoder upstream hands over checked read requests.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: Status bit 1 follows the fault state of the channel at 2303.
// RQ2: Status bit 2 follows the fault state of the channel at 2305.
// RQ3: Status bit 3 follows the fault state of the channel at 2307.
// RQ4: Every read response carries function code 03.
// RQ5: Values go out as 16-bit words high byte first, lowest word first.
// RQ6: Status bit 15 is set on a settings change and cleared when read.
// RQ7: Status bit 0 follows the fault state of the channel at 2301.
// RQ8: The link runs at 19200 baud, eight data bits, no parity, one stop.
// RQ9: Status sits read-only at 2300, four float values from 2301 on.
// RQ10: Status bits 4 to 14 always read zero and cannot be changed.
module status_readout
  import readout_pkg::*;
#(
  parameter int QTY_MAX = MAX_QTY,
  parameter int BIT_LEN = BIT_CYCLES
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Read request from the frame decoder
  input wire logic req_valid,
  input wire logic [7:0] dev_addr,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_qty,
  output logic req_ready,
  // Channel state
  input wire logic [3:0] ch_fault,
  input wire logic setting_changed,
  input wire logic [31:0] ch_value0,
  input wire logic [31:0] ch_value1,
  input wire logic [31:0] ch_value2,
  input wire logic [31:0] ch_value3,
  // Outputs
  output logic [15:0] status_word,
  output logic txd
);
  // Quantity must fit the request field and the byte counter
  if (QTY_MAX < 1 || QTY_MAX > MAX_QTY) begin : g_qty_check
    $error("QTY_MAX out of range");
  end

  typedef enum logic {IDLE, SEND} st_t;
  st_t state;
  logic [7:0] addr_q;
  logic [15:0] base_q;
  logic [7:0] count_q;
  logic [7:0] byte_idx;
  logic [15:0] crc;
  logic tx_ready;

  // RQ5: two registers per float, low word at the lower address
  function automatic logic [15:0] reg_word(input logic [15:0] a,
      input logic [15:0] st, input logic [127:0] vals);
    logic [15:0] off;
    logic [6:0] sel;
    off = a - CH0_ADDR;
    // Odd offsets pick the upper half of a float
    sel = {off[2:0], 4'h0};
    reg_word = 16'h0000;
    if (a == STATUS_ADDR) begin
      reg_word = st;
    end else if (a >= CH0_ADDR && a <= LAST_ADDR) begin
      reg_word = vals[sel +: 16];
    end
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c,
      input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crc_step = r;
  endfunction

  wire [127:0] vals = {ch_value3, ch_value2, ch_value1, ch_value0};
  wire qty_ok = req_qty != 8'h00 && 32'(req_qty) <= QTY_MAX;
  wire start = state == IDLE && req_valid && qty_ok;
  wire [7:0] data_bytes = 8'({count_q, 1'b0});
  wire [7:0] frame_last = 8'(data_bytes + 8'(HDR_BYTES + CRC_BYTES - 1));
  wire [7:0] crc_first = 8'(frame_last - 8'h01);
  wire [7:0] data_idx = 8'(byte_idx - 8'(HDR_BYTES));
  wire [15:0] cur_addr = base_q + {9'h000, data_idx[7:1]};
  wire [15:0] cur_word = reg_word(cur_addr, status_word, vals);
  wire in_data = byte_idx >= 8'(HDR_BYTES) && byte_idx < crc_first;
  // Sender paces the frame, so a low clk_en only stretches it
  wire tx_take = state == SEND && tx_ready && clk_en;
  wire last_byte = byte_idx == frame_last;
  // RQ6: reading the status high byte counts as the master's read
  wire status_read = tx_take && in_data && !data_idx[0]
    && cur_addr == STATUS_ADDR;
  // RQ6: change flag next value
  wire next_changed = setting_changed
    || (status_word[CHANGED_BIT] && !status_read);
  logic [7:0] tx_byte;

  // RQ4: header carries the read function code
  // RQ5: high byte of each word first
  always_comb begin
    tx_byte = 8'h00;
    if (byte_idx == 8'h00) begin
      tx_byte = addr_q;
    end else if (byte_idx == 8'h01) begin
      tx_byte = FUNC_READ;
    end else if (byte_idx == 8'h02) begin
      tx_byte = data_bytes;
    end else if (in_data) begin
      tx_byte = data_idx[0] ? cur_word[7:0] : cur_word[15:8];
    end else if (byte_idx == crc_first) begin
      tx_byte = crc[7:0];
    end else begin
      tx_byte = crc[15:8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= IDLE;
      req_ready <= 1'b1;
      addr_q <= 8'h00;
      base_q <= 16'h0000;
      count_q <= 8'h00;
      byte_idx <= 8'h00;
      crc <= CRC_INIT;
    end else if (clk_en) begin
      if (start) begin
        state <= SEND;
        req_ready <= 1'b0;
        addr_q <= dev_addr;
        base_q <= req_addr;
        count_q <= req_qty;
        byte_idx <= 8'h00;
        crc <= CRC_INIT;
      end else if (tx_take) begin
        byte_idx <= byte_idx + 8'h01;
        if (byte_idx < crc_first) begin
          crc <= crc_step(crc, tx_byte);
        end
        if (last_byte) begin
          state <= IDLE;
          req_ready <= 1'b1;
        end
      end
    end
  end

  // RQ1: RQ2: RQ3: RQ7: fault bits follow channels
  // RQ10: unused bits held at zero
  // RQ6: set wins over the read clear
  // RQ9: no write path reaches this word
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_word <= STATUS_RESET;
    end else if (clk_en) begin
      status_word <= 16'h0000;
      status_word[FAULT_HI:FAULT_LO] <= ch_fault;
      status_word[CHANGED_BIT] <= next_changed;
    end
  end

  // RQ8: bytes leave at 19200 8/N/1
  serial_byte_tx #(.BIT_LEN(BIT_LEN)) u_tx (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .data(tx_byte),
    .valid(state == SEND),
    .ready(tx_ready),
    .txd(txd)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_fault_ch0: assert property (clk_en |=> // RQ7
    status_word[0] == $past(ch_fault[0])) else $error("bit 0 wrong");
  a_fault_ch1: assert property (clk_en |=> // RQ1
    status_word[1] == $past(ch_fault[1])) else $error("bit 1 wrong");
  a_fault_ch2: assert property (clk_en |=> // RQ2
    status_word[2] == $past(ch_fault[2])) else $error("bit 2 wrong");
  a_fault_ch3: assert property (clk_en |=> // RQ3
    status_word[3] == $past(ch_fault[3])) else $error("bit 3 wrong");
  a_unused_zero: assert property ( // RQ10
    status_word[14:4] == 11'h000) else $error("unused bits set");
  a_change_set: assert property (clk_en && setting_changed |=> // RQ6
    status_word[CHANGED_BIT]) else $error("change flag lost");
  a_change_clear: assert property (clk_en && status_read // RQ6
    && !setting_changed |=> !status_word[CHANGED_BIT])
    else $error("change flag not cleared by read");
  a_func_code: assert property (tx_take && byte_idx == 8'h01 |-> // RQ4
    tx_byte == FUNC_READ) else $error("wrong function code");
  a_word_order: assert property (tx_take && in_data // RQ5
    && cur_addr == CH0_ADDR && !data_idx[0] |-> tx_byte == ch_value0[15:8])
    else $error("float word order wrong");
  a_status_map: assert property (status_read |-> // RQ9
    tx_byte == status_word[15:8]) else $error("status not at 2300");
  a_ready_idle: assert property (req_ready == (state == IDLE)) // RQ4
    else $error("ready disagrees with idle");
  a_addr_echo: assert property (tx_take && byte_idx == 8'h00 |-> // RQ4
    tx_byte == addr_q) else $error("address not echoed");
  // Out-of-map reads answer zero rather than an exception
  a_unmapped_zero: assert property (tx_take && in_data // RQ9
    && (cur_addr < STATUS_ADDR || cur_addr > LAST_ADDR)
    |-> tx_byte == 8'h00) else $error("unmapped register not zero");
  a_frame_end: assert property (tx_take && last_byte |=> // RQ4
    state == IDLE && req_ready) else $error("frame did not end");
  // Bad quantities are dropped with no reply
  a_qty_refused: assert property (state == IDLE && req_valid // RQ4
    && clk_en && !qty_ok |=> state == IDLE)
    else $error("bad quantity taken");
  a_busy_hold: assert property (state == SEND && req_valid |=> // RQ4
    $stable(base_q) && $stable(count_q))
    else $error("request taken while busy");
  // Frozen cycles must not move the frame or the flags
  a_freeze_status: assert property (!clk_en |=> $stable(status_word)) // RQ6
    else $error("status moved while frozen");
  a_freeze_frame: assert property (!clk_en |=> // RQ5
    $stable(byte_idx) && $stable(state))
    else $error("frame moved while frozen");

  c_status_read: cover property (status_read);
  c_float_read: cover property (tx_take && in_data && cur_addr == CH3_ADDR);
  c_frame_done: cover property (tx_take && last_byte);
  c_change_race: cover property (status_read && setting_changed);
  c_frozen_change: cover property (!clk_en && setting_changed);
endmodule
`default_nettype wire

// ==== test_status_readout.sv ====
// Bench for the register readout: status bits and read responses.
// Assumes the master model decodes the line at a short bit length.
`timescale 1ns/1ps
`default_nettype none
module test_status_readout
  import readout_pkg::*;
;
  localparam int BL = 4;
  localparam int QM = 12;
  logic sys_clk, srst, clk_en, req_valid, req_ready, setting_changed;
  logic txd, rx_done, frame_err;
  logic [7:0] dev_addr, req_qty, rx_data;
  logic [15:0] req_addr, status_word;
  logic [3:0] ch_fault;
  logic [31:0] cv [4];
  logic [7:0] rxq [$];
  int miscompares = 0;
  int checks = 0;
  status_readout #(.QTY_MAX(QM), .BIT_LEN(BL)) DUT (.sys_clk(sys_clk),
    .srst(srst), .clk_en(clk_en), .req_valid(req_valid), .dev_addr(dev_addr),
    .req_addr(req_addr), .req_qty(req_qty), .req_ready(req_ready),
    .ch_fault(ch_fault), .setting_changed(setting_changed),
    .ch_value0(cv[0]), .ch_value1(cv[1]), .ch_value2(cv[2]),
    .ch_value3(cv[3]), .status_word(status_word), .txd(txd));
  modbus_master_model #(.BIT_LEN(BL)) master (.sys_clk(sys_clk), .txd(txd),
    .rx_data(rx_data), .rx_done(rx_done), .frame_err(frame_err));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (rx_done === 1'b1) rxq.push_back(rx_data);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("Counts: %0d checks, %0d miscompares", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [15:0] wd(input int i);
    return {rxq[i], rxq[i + 1]};
  endfunction
  function automatic logic [15:0] crc(input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, rxq[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic read_regs(input logic [15:0] a, input int q);
    int n;
    rxq.delete();
    req_addr = a;
    req_qty = 8'(q);
    req_valid = 1'b1;
    repeat (2) @(negedge sys_clk);
    // Second edge falls while busy and must be ignored
    req_valid = 1'b0;
    check({15'h0, req_ready}, 16'h0000);
    n = 0;
    // Bounded so a lost byte cannot hang the run
    while (rxq.size() < 5 + 2 * q && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    check(16'(rxq.size()), 16'(5 + 2 * q));
    n = 3 + 2 * q;
    check({rxq[0], rxq[1]}, 16'h2103);
    check({8'h00, rxq[2]}, 16'(2 * q));
    check({rxq[n + 1], rxq[n]}, crc(n));
    check({15'h0, req_ready}, 16'h0001);
  endtask
  task automatic test_faults;
    for (int i = 0; i < 5; i++) begin
      ch_fault = (i < 4) ? 4'(1 << i) : 4'hf;
      repeat (2) @(negedge sys_clk);
      check(status_word, 16'(ch_fault));
    end
    // Frozen clock enable: status and the change flag must not move
    clk_en = 1'b0;
    ch_fault = 4'ha;
    setting_changed = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(status_word, 16'h000f);
    setting_changed = 1'b0;
    clk_en = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(status_word, 16'h000a);
    $display("test_faults done");
  endtask
  task automatic test_changed;
    ch_fault = 4'h5;
    setting_changed = 1'b1;
    @(negedge sys_clk);
    setting_changed = 1'b0;
    @(negedge sys_clk);
    check(status_word, 16'h8005);
    read_regs(16'd2300, 1);
    check(wd(3), 16'h8005);
    check(status_word, 16'h0005);
    read_regs(16'd2300, 1);
    check(wd(3), 16'h0005);
    $display("test_changed done");
  endtask
  task automatic test_values;
    for (int k = 0; k < 4; k++) begin
      cv[k] = {8'ha0 + 8'(k), 8'hb1, 8'hc0 + 8'(k), 8'hd3};
    end
    read_regs(16'd2300, 9);
    check(wd(3), 16'h0005);
    for (int k = 0; k < 4; k++) begin
      check(wd(5 + 4 * k), cv[k][15:0]);
      check(wd(7 + 4 * k), cv[k][31:16]);
    end
    read_regs(16'd2309, 1);
    check(wd(3), 16'h0000);
    $display("test_values done");
  endtask
  task automatic test_limits;
    // Zero and one past the limit must both be ignored
    for (int q = 0; q <= QM + 1; q += QM + 1) begin
      rxq.delete();
      req_qty = 8'(q);
      req_valid = 1'b1;
      repeat (3) @(negedge sys_clk);
      req_valid = 1'b0;
      repeat (60) @(negedge sys_clk);
      check({15'h0, req_ready}, 16'h0001);
      check(16'(rxq.size()), 16'h0000);
    end
    read_regs(16'd2300, QM);
    $display("test_limits done");
  endtask
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    req_valid = 1'b0;
    dev_addr = 8'h21;
    req_addr = 16'h0000;
    req_qty = 8'h00;
    ch_fault = 4'h0;
    setting_changed = 1'b0;
    foreach (cv[k]) cv[k] = 32'h0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check(status_word, 16'h0000);
    srst = 1'b0;
    test_faults();
    test_changed();
    test_values();
    test_limits();
    check({15'h0, frame_err}, 16'h0000);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
